// File: core/ioe_expander.sv
// Eight-pin general-purpose port reached as a slave on a two-wire bus.
// Assumes the serial pins are oversampled on clk_link_i, several times
// faster than the serial clock, and that the pin buffers resolve the
// enables into wire levels outside this module.
`include "ioe_map.svh"

module ioe_expander (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_0_i,
  input wire logic addr_strap_1_i,
  input wire logic addr_strap_2_i,
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_o,
  output logic chg_alert_n_o,
  output logic chg_alert_oe_o
);

  // -----------------------------------------------------------------------
  // Reset value of the link state record.
  // -----------------------------------------------------------------------
  localparam ioe_pkg::ioe_link_t LINK_RST = '{
    st: ioe_pkg::ST_IDLE,
    cnt: `IOE_BIT_FIRST,
    sh: `IOE_RST_BYTE,
    rw: 1'b0,
    cmd_seen: 1'b0,
    sel: `IOE_RST_SEL,
    ack_drive: 1'b0,
    scl_q: 1'b1,
    sda_q: 1'b1,
    sda_oe: 1'b0,
    req_tgl: 1'b0,
    x_wr: 1'b0,
    x_sel: `IOE_RST_SEL,
    x_data: `IOE_RST_BYTE
  };

  // -----------------------------------------------------------------------
  // Declarations.
  // -----------------------------------------------------------------------
  ioe_pkg::ioe_link_t l;
  ioe_pkg::ioe_link_t next_l;
  ioe_pkg::ioe_sys_t s;
  ioe_pkg::ioe_sys_t next_s;

  logic [1:0] bus_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] strap_s;
  logic rst_link_n;
  logic [7:0] pins_s;
  logic req_pulse;
  logic [7:0] in_view;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] byte_in;

  // -----------------------------------------------------------------------
  // Synchronisers into the link domain.
  // -----------------------------------------------------------------------
  // The reset is taken over into the link domain as a plain level, so the
  // serial engine idles a couple of link clocks after the system reset.
  ioe_sync #(
    .WIDTH(1)
  ) u_rst_link (
    .clk_i(clk_link_i),
    .d_i(nrst_i),
    .q_o(rst_link_n)
  );

  ioe_sync #(
    .WIDTH(2)
  ) u_bus_sync (
    .clk_i(clk_link_i),
    .d_i({scl_i, sda_i}),
    .q_o(bus_s)
  );

  ioe_sync #(
    .WIDTH(3)
  ) u_strap_sync (
    .clk_i(clk_link_i),
    .d_i({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i}),
    .q_o(strap_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // -----------------------------------------------------------------------
  // Synchronisers into the system domain.
  // -----------------------------------------------------------------------
  ioe_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .d_i(port_pin_i),
    .q_o(pins_s)
  );

  // A request from the link holds its selector and data steady until the
  // next request, nine serial clocks later, so only the toggle crosses.
  ioe_tgl_rx u_req_rx (
    .clk_i(clk_sys_i),
    .rst_n_i(nrst_i),
    .tgl_i(l.req_tgl),
    .pulse_o(req_pulse)
  );

  // -----------------------------------------------------------------------
  // Serial bus conditions.
  // -----------------------------------------------------------------------
  assign scl_rise = scl_s & ~l.scl_q;
  assign scl_fall = ~scl_s & l.scl_q;
  assign bus_start = scl_s & l.scl_q & l.sda_q & ~sda_s;
  assign bus_stop = scl_s & l.scl_q & ~l.sda_q & sda_s;
  assign byte_in = {l.sh[6:0], sda_s};

  // -----------------------------------------------------------------------
  // Link-side serial engine.
  // -----------------------------------------------------------------------
  // Read data are taken from the system domain's answer word at least half a
  // serial clock after the request, which the oversampling ratio covers;
  // the slave never stretches the clock.
  always_comb begin
    next_l = l;
    next_l.scl_q = scl_s;
    next_l.sda_q = sda_s;
    if (!rst_link_n) begin
      next_l = LINK_RST;
    end else if (bus_start) begin
      next_l.st = ioe_pkg::ST_ADDR;
      next_l.cnt = `IOE_BIT_FIRST;
      next_l.sda_oe = 1'b0;
      next_l.ack_drive = 1'b0;
    end else if (bus_stop) begin
      next_l.st = ioe_pkg::ST_IDLE;
      next_l.sda_oe = 1'b0;
      next_l.ack_drive = 1'b0;
    end else begin
      unique case (l.st)
        ioe_pkg::ST_IDLE: begin
          next_l.sda_oe = 1'b0;
        end
        ioe_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_l.sh = byte_in;
            next_l.cnt = l.cnt + `IOE_BIT_STEP;
            if (l.cnt == `IOE_BIT_LAST) begin
              if (byte_in[7:1] == {`IOE_ADDR_HI, strap_s}) begin
                next_l.st = ioe_pkg::ST_ACK;
                next_l.rw = byte_in[0];
                next_l.cmd_seen = 1'b0;
                if (byte_in[0]) begin
                  next_l.req_tgl = ~l.req_tgl;
                  next_l.x_wr = 1'b0;
                  next_l.x_sel = l.sel;
                end
              end else begin
                next_l.st = ioe_pkg::ST_IDLE;
              end
            end
          end
        end
        ioe_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (!l.ack_drive) begin
              next_l.ack_drive = 1'b1;
              next_l.sda_oe = 1'b1;
            end else begin
              next_l.ack_drive = 1'b0;
              next_l.cnt = `IOE_BIT_FIRST;
              if (l.rw) begin
                next_l.st = ioe_pkg::ST_READ;
                next_l.sh = s.rd_word;
                next_l.sda_oe = ~s.rd_word[7];
              end else begin
                next_l.st = ioe_pkg::ST_WRITE;
                next_l.sda_oe = 1'b0;
              end
            end
          end
        end
        ioe_pkg::ST_WRITE: begin
          if (scl_rise) begin
            next_l.sh = byte_in;
            next_l.cnt = l.cnt + `IOE_BIT_STEP;
            if (l.cnt == `IOE_BIT_LAST) begin
              next_l.st = ioe_pkg::ST_ACK;
              if (!l.cmd_seen) begin
                next_l.cmd_seen = 1'b1;
                next_l.sel = byte_in[1:0];
              end else begin
                next_l.req_tgl = ~l.req_tgl;
                next_l.x_wr = 1'b1;
                next_l.x_sel = l.sel;
                next_l.x_data = byte_in;
              end
            end
          end
        end
        ioe_pkg::ST_READ: begin
          if (scl_fall) begin
            next_l.sh = {l.sh[6:0], 1'b0};
            next_l.sda_oe = ~l.sh[6];
          end else if (scl_rise) begin
            next_l.cnt = l.cnt + `IOE_BIT_STEP;
            if (l.cnt == `IOE_BIT_LAST) begin
              next_l.st = ioe_pkg::ST_MACK;
            end
          end
        end
        ioe_pkg::ST_MACK: begin
          if (scl_fall) begin
            next_l.sda_oe = 1'b0;
          end else if (scl_rise) begin
            if (!sda_s) begin
              // The master wants another byte from the same register.
              next_l.st = ioe_pkg::ST_ACK;
              next_l.ack_drive = 1'b1;
              next_l.req_tgl = ~l.req_tgl;
              next_l.x_wr = 1'b0;
              next_l.x_sel = l.sel;
            end else begin
              next_l.st = ioe_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_l = LINK_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link_i) begin
    l <= next_l;
  end

  // -----------------------------------------------------------------------
  // Register side.
  // -----------------------------------------------------------------------
  assign in_view = pins_s ^ s.pol_inv;

  // A read of the input register also takes a new capture, which is what
  // lets software quiet the alert; pins driven as outputs never alert.
  always_comb begin
    next_s = s;
    if (!nrst_i) begin
      next_s.out_latch = `IOE_RST_OUT;
      next_s.pol_inv = `IOE_RST_POL;
      next_s.drive_en = `IOE_RST_DRV;
      next_s.drive_d1 = `IOE_RST_DRV;
      next_s.drive_d2 = `IOE_RST_DRV;
      next_s.in_raw = pins_s;
      next_s.rd_word = `IOE_RST_BYTE;
      next_s.alert_oe = 1'b0;
    end else begin
      if (req_pulse) begin
        if (l.x_wr) begin
          unique case (l.x_sel)
            `IOE_SEL_IN: begin
              next_s.in_raw = s.in_raw;
            end
            `IOE_SEL_OUT: begin
              next_s.out_latch = l.x_data;
            end
            `IOE_SEL_POL: begin
              next_s.pol_inv = l.x_data;
            end
            `IOE_SEL_CFG: begin
              next_s.drive_en = ~l.x_data;
            end
          endcase
        end else begin
          unique case (l.x_sel)
            `IOE_SEL_IN: begin
              next_s.rd_word = in_view;
              next_s.in_raw = pins_s;
            end
            `IOE_SEL_OUT: begin
              next_s.rd_word = s.out_latch;
            end
            `IOE_SEL_POL: begin
              next_s.rd_word = s.pol_inv;
            end
            `IOE_SEL_CFG: begin
              next_s.rd_word = ~s.drive_en;
            end
          endcase
        end
      end
      // A pin just released still shows its driven level through the
      // synchroniser for a few clocks, so it stays masked until then; a
      // real change on such a pin alerts up to two clocks late instead.
      next_s.drive_d1 = s.drive_en;
      next_s.drive_d2 = s.drive_d1;
      next_s.alert_oe = |((pins_s ^ next_s.in_raw) &
                          ~(next_s.drive_en | s.drive_en | s.drive_d1 |
                            s.drive_d2));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    s <= next_s;
  end

  // -----------------------------------------------------------------------
  // Outputs.
  // -----------------------------------------------------------------------
  // Open-drain pins only ever drive low; the enable decides the wire.
  assign sda_o = 1'b0;
  assign sda_oe_o = l.sda_oe;
  assign port_pin_o = s.out_latch;
  assign port_pin_oe_o = s.drive_en;
  assign chg_alert_n_o = 1'b0;
  assign chg_alert_oe_o = s.alert_oe;

endmodule : ioe_expander

// File: core/ioe_map.svh
// Named constants of the eight-pin serial port expander.
// Assumes inclusion by bare name from the design files that need them.
`ifndef IOE_MAP_SVH
`define IOE_MAP_SVH

// -----------------------------------------------------------------------
// Slave address and register selection.
// -----------------------------------------------------------------------
`define IOE_ADDR_HI 4'h7
`define IOE_SEL_IN 2'h0
`define IOE_SEL_OUT 2'h1
`define IOE_SEL_POL 2'h2
`define IOE_SEL_CFG 2'h3

// -----------------------------------------------------------------------
// Reset values and serial byte framing.
// -----------------------------------------------------------------------
`define IOE_RST_OUT 8'hff
`define IOE_RST_POL 8'h00
`define IOE_RST_DRV 8'h00
`define IOE_RST_BYTE 8'h00
`define IOE_RST_SEL 2'h0
`define IOE_BIT_FIRST 3'h0
`define IOE_BIT_LAST 3'h7
`define IOE_BIT_STEP 3'h1

`endif

// File: core/ioe_pkg.sv
// Types shared by the port expander modules.
// Assumes nothing of its surroundings.
package ioe_pkg;

  // -----------------------------------------------------------------------
  // Serial slave phases.
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_MACK
  } ioe_state_t;

  // -----------------------------------------------------------------------
  // State of the link-side logic, clocked by the link clock.
  // -----------------------------------------------------------------------
  typedef struct packed {
    ioe_state_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic cmd_seen;
    logic [1:0] sel;
    logic ack_drive;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic req_tgl;
    logic x_wr;
    logic [1:0] x_sel;
    logic [7:0] x_data;
  } ioe_link_t;

  // -----------------------------------------------------------------------
  // State of the register side, clocked by the system clock.
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out_latch;
    logic [7:0] pol_inv;
    logic [7:0] drive_en;
    logic [7:0] drive_d1;
    logic [7:0] drive_d2;
    logic [7:0] in_raw;
    logic [7:0] rd_word;
    logic alert_oe;
  } ioe_sys_t;

endpackage : ioe_pkg

// File: core/ioe_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
module ioe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } ioe_sync_st_t;

  ioe_sync_st_t r;
  ioe_sync_st_t next_r;

  // The first stage feeds only the second stage.
  always_comb begin
    next_r.meta = d_i;
    next_r.safe = r.meta;
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  assign q_o = r.safe;

endmodule : ioe_sync

// File: core/ioe_tgl_rx.sv
// Receives a toggle from another clock domain and gives a one-cycle pulse.
// Assumes the source toggles at most once per several destination clocks.
module ioe_tgl_rx (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tgl_i,
  output logic pulse_o
);

  typedef struct packed {
    logic last;
  } ioe_tgl_st_t;

  ioe_tgl_st_t r;
  ioe_tgl_st_t next_r;
  logic tgl_s;

  ioe_sync #(
    .WIDTH(1)
  ) u_sync (
    .clk_i(clk_i),
    .d_i(tgl_i),
    .q_o(tgl_s)
  );

  // The last seen value tracks the source across reset, so no false event.
  always_comb begin
    next_r.last = tgl_s;
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  assign pulse_o = rst_n_i & (tgl_s ^ r.last);

endmodule : ioe_tgl_rx

// File: tb/ioe_i2c_master.sv
// Behavioural two-wire bus master for the port expander bench.
// Assumes the bench resolves the data wire with a pull-up.
module ioe_i2c_master (
  input wire logic clk_link_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Eleven link cycles a quarter keeps each clock phase above the
  // oversampling minimum of the slave while keeping the run short.
  localparam int QTR = 11;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic q;
    repeat (QTR) @(posedge clk_link_i);
  endtask : q

  // Also serves as a repeated start when the clock is low.
  task automatic start;
    sda_low_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask : start

  task automatic stop;
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b0;
    q();
  endtask : stop

  task automatic bit_x(input logic b, output logic r);
    sda_low_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    scl_o <= 1'b0;
    q();
  endtask : bit_x

  // Bytes go out most significant bit first; the ninth bit is released.
  task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, ack_n);
  endtask : xfer
endmodule : ioe_i2c_master

// File: tb/ioe_expander_properties.sv
// Port-level assertions for the port expander.
// Assumes the serial clock rests high between frames.
module ioe_expander_properties (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clk_link_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] port_pin_o,
  input wire logic [7:0] port_pin_oe_o,
  input wire logic chg_alert_n_o,
  input wire logic chg_alert_oe_o
);
  // A long high serial clock means no write can still be landing.
  logic [6:0] scl_hi;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || !scl_i) begin
      scl_hi <= 7'h00;
    end else if (scl_hi != 7'h7f) begin
      scl_hi <= scl_hi + 7'h01;
    end
  end

  a_sda_open_drain: assert property (@(posedge clk_link_i)
    disable iff (!nrst_i) sda_o == 1'b0) else $error("data drives high");
  a_alert_open_drain: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) chg_alert_n_o == 1'b0) else $error("alert high");
  a_reset_pins: assert property (@(posedge clk_sys_i)
    !nrst_i ##1 !nrst_i |-> port_pin_oe_o == 8'h00 &&
    port_pin_o == 8'hff && !chg_alert_oe_o) else $error("reset values");
  a_link_reset_idle: assert property (@(posedge clk_link_i)
    !nrst_i [*4] |-> !sda_oe_o) else $error("data held in reset");
  a_alert_all_out: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) (port_pin_oe_o == 8'hff) [*4] |->
    !chg_alert_oe_o) else $error("alert with no input pin");
  a_alert_needs_input: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) $rose(chg_alert_oe_o) |->
    $past(port_pin_oe_o) != 8'hff) else $error("alert cause");
  a_sda_change_low: assert property (@(posedge clk_link_i)
    disable iff (!nrst_i) $changed(sda_oe_o) |-> !scl_i)
    else $error("data moved while clock high");
  a_latch_hold: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) scl_hi > 7'h64 |-> $stable(port_pin_o) &&
    $stable(port_pin_oe_o)) else $error("pins moved while idle");

  c_alert: cover property (@(posedge clk_sys_i) $rose(chg_alert_oe_o));
  c_dir: cover property (@(posedge clk_sys_i) $changed(port_pin_oe_o));
  c_ack: cover property (@(posedge clk_link_i) $rose(sda_oe_o));
endmodule : ioe_expander_properties

bind ioe_expander ioe_expander_properties u_props (
  .clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i),
  .clk_link_i(clk_link_i),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .port_pin_o(port_pin_o),
  .port_pin_oe_o(port_pin_oe_o),
  .chg_alert_n_o(chg_alert_n_o),
  .chg_alert_oe_o(chg_alert_oe_o)
);

// File: tb/tb_ioe_expander.sv
// Self-checking bench for the port expander.
// Assumes pull-ups on the data wire and on released port pins.
module tb_ioe_expander;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, clk_link_i, nrst_i, sda_oe, m_scl, m_low, alert_oe;
  logic [2:0] strap;
  logic [7:0] ext, pin_o, pin_oe, pin_w;
  logic sda_w;
  int error_cnt, n_checks;

  assign sda_w = !(sda_oe | m_low);
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & ext);

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    clk_link_i = 1'b0;
    #7;
    forever #40 clk_link_i = ~clk_link_i;
  end

  ioe_expander dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .clk_link_i(clk_link_i), .scl_i(m_scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .addr_strap_0_i(strap[0]),
    .addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[2]),
    .port_pin_i(pin_w), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe),
    .chg_alert_n_o(), .chg_alert_oe_o(alert_oe));
  ioe_i2c_master mst (.clk_link_i(clk_link_i), .sda_i(sda_w),
    .scl_o(m_scl), .sda_low_o(m_low));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr_reg(input logic [1:0] r, input logic [7:0] d);
    logic [2:0] a;
    logic [7:0] x;
    mst.start();
    mst.xfer({4'h7, strap, 1'b0}, x, a[2]);
    mst.xfer({6'h00, r}, x, a[1]);
    mst.xfer(d, x, a[0]);
    mst.stop();
    chk("write acks", 8'h00, {5'h00, a});
  endtask : wr_reg

  task automatic rd_now(input logic [7:0] e, input string nm);
    logic a;
    logic [7:0] x;
    mst.start();
    mst.xfer({4'h7, strap, 1'b1}, x, a);
    mst.xfer(8'hff, x, a);
    mst.stop();
    chk(nm, e, x);
  endtask : rd_now

  task automatic rd_reg(input logic [1:0] r, input logic [7:0] e,
                        input string nm);
    logic a;
    logic [7:0] x;
    mst.start();
    mst.xfer({4'h7, strap, 1'b0}, x, a);
    mst.xfer({6'h00, r}, x, a);
    rd_now(e, nm);
  endtask : rd_reg

  task automatic wait_alert(input logic e);
    for (int i = 0; i < 40 && alert_oe !== e; i++) @(posedge clk_sys_i);
    chk("alert", {7'h00, e}, {7'h00, alert_oe});
    if (alert_oe !== e) wrap_up();
  endtask : wait_alert

  task automatic t_defaults;
    chk("dir", 8'h00, pin_oe);
    chk("out", 8'hff, pin_o);
    rd_reg(2'h1, 8'hff, "out reg");
    rd_reg(2'h2, 8'h00, "pol reg");
    rd_reg(2'h3, 8'hff, "dir reg");
    $display("t_defaults finished");
  endtask : t_defaults

  task automatic t_address;
    logic a, b;
    logic [7:0] x;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys_i) strap <= s[2:0];
      repeat (20) @(posedge clk_sys_i);
      mst.start();
      mst.xfer({4'h7, strap, 1'b0}, x, a);
      mst.stop();
      mst.start();
      mst.xfer({4'h6, strap, 1'b0}, x, b);
      mst.stop();
      chk("addr acks", 8'h01, {6'h00, a, b});
    end
    $display("t_address finished");
  endtask : t_address

  task automatic t_out_dir;
    wr_reg(2'h3, 8'h00);
    chk("all out", 8'hff, pin_oe);
    wr_reg(2'h1, 8'ha5);
    wr_reg(2'h3, 8'h0f);
    chk("dir", 8'hf0, pin_oe);
    rd_reg(2'h1, 8'ha5, "out reg");
    rd_reg(2'h3, 8'h0f, "dir reg");
    chk("held out", 8'ha5, pin_o);
    $display("t_out_dir finished");
  endtask : t_out_dir

  task automatic t_input;
    wr_reg(2'h3, 8'hff);
    @(posedge clk_sys_i) ext <= 8'h3c;
    wr_reg(2'h2, 8'h0f);
    rd_reg(2'h0, 8'h33, "in reg");
    wr_reg(2'h0, 8'h55);
    rd_now(8'h33, "in kept");
    wr_reg(2'h2, 8'h0f);
    rd_now(8'h0f, "pointer");
    $display("t_input finished");
  endtask : t_input

  task automatic t_alert;
    wait_alert(1'b0);
    @(posedge clk_sys_i) ext <= 8'h3d;
    wait_alert(1'b1);
    rd_reg(2'h0, 8'h32, "in new");
    wait_alert(1'b0);
    $display("t_alert finished");
  endtask : t_alert

  task automatic t_reset;
    logic b;
    wr_reg(2'h1, 8'h00);
    mst.start();
    repeat (4) mst.bit_x(1'b0, b);
    @(posedge clk_sys_i) nrst_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    mst.stop();
    chk("out", 8'hff, pin_o);
    chk("dir", 8'h00, pin_oe);
    rd_reg(2'h2, 8'h00, "pol reg");
    $display("t_reset finished");
  endtask : t_reset

  initial begin
    nrst_i = 1'b0;
    strap = 3'h0;
    ext = 8'hff;
    error_cnt = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    t_defaults();
    t_address();
    t_out_dir();
    t_input();
    t_alert();
    t_reset();
    wrap_up();
  end
endmodule : tb_ioe_expander
